// ==== verilog/mcwsx_pkg.sv ====
// package: opcodes, field positions, reset values and cycle counts of the decoder
package mcwsx_pkg;
  localparam int          WORD_W          = 16;
  localparam int          PC_W            = 10;
  localparam int          ROWS            = 6;
  localparam int          ALU_REGS        = 8;
  // opcode patterns
  localparam logic [10:0] WAIT5_OP        = 11'h1a8;   // bits 15:5 = 00110101000
  localparam logic [10:0] WAIT6_OP        = 11'h1b3;   // bits 15:5 = 00110110011
  localparam logic [15:0] SPIWR_OP        = 16'h3541;
  localparam logic [12:0] XOR_OP          = 13'h05da;  // bits 15:3 = 0010111011010
  localparam int          WAIT_OP_LSB     = 5;
  localparam int          XOR_OP_LSB      = 3;
  // reset values
  localparam logic [15:0] WORD_RST        = 16'h0000;
  localparam logic [9:0]  PC_RST          = 10'h000;
  localparam logic [15:0] ALL_ONES        = 16'hffff;
  // backdoor write occupies two core cycles
  localparam logic [1:0]  SPIWR_CYCLES    = 2'h2;
  typedef enum logic [1:0] {
    MCWSX_RUN  = 2'b00,
    MCWSX_WAIT = 2'b01,
    MCWSX_SPI  = 2'b10
  } mcwsx_state_t;
endpackage

// ==== verilog/mcwsx_wait_sel.sv ====
// wait-row selector: maps a wait opcode's five-bit field to a six-bit row enable mask
module mcwsx_wait_sel
  import mcwsx_pkg::*;
(
  // operand
  input  wire logic [4:0]      field,
  input  wire logic            row6_variant,
  // decoded rows
  output logic [ROWS-1:0]      row_enable
);
  logic [5:0] code;

  // six-bit selector code, then table decode of combinations
  always_comb begin
    code       = {row6_variant, field};
    row_enable = '0;
    if (!code[5]) begin
      row_enable = {1'b0, code[4:0]};
    end else begin
      unique case (code[4:0])
        5'h00: row_enable = 6'h20;
        5'h01: row_enable = 6'h21;
        5'h02: row_enable = 6'h22;
        5'h03: row_enable = 6'h24;
        5'h04: row_enable = 6'h28;
        5'h05: row_enable = 6'h30;
        5'h06: row_enable = 6'h23;
        5'h07: row_enable = 6'h25;
        5'h08: row_enable = 6'h29;
        5'h09: row_enable = 6'h31;
        5'h0a: row_enable = 6'h26;
        5'h0b: row_enable = 6'h2a;
        5'h0c: row_enable = 6'h32;
        5'h0d: row_enable = 6'h2c;
        5'h0e: row_enable = 6'h38;
        5'h0f: row_enable = 6'h27;
        5'h10: row_enable = 6'h2b;
        5'h11: row_enable = 6'h33;
        5'h12: row_enable = 6'h2d;
        5'h13: row_enable = 6'h35;
        5'h14: row_enable = 6'h39;
        5'h15: row_enable = 6'h2e;
        5'h16: row_enable = 6'h36;
        5'h17: row_enable = 6'h3a;
        5'h18: row_enable = 6'h3c;
        5'h19: row_enable = 6'h2f;
        5'h1a: row_enable = 6'h37;
        5'h1b: row_enable = 6'h3b;
        5'h1c: row_enable = 6'h3d;
        5'h1d: row_enable = 6'h3f;
        default: row_enable = 6'h00;  // codes 111110, 111111 unassigned
      endcase
    end
  end
endmodule

// ==== verilog/mcwsx_core.sv ====
// core: decodes and executes wait, backdoor spi write and xor instructions
// Summary of operation
// - wait without row 6: opcode 00110101000
// - wait with row 6: opcode 00110110011
// - wait holds counter, fired row loads destination
// - six-bit row selector, zero waits forever
// - backdoor write issues one-word request
// - address sampled at issue
// - data sampled at issue
// - backdoor write takes two cycles
// - next-instruction register change does not alter the write
// - backdoor write opcode 0011010101000001
// - address source may be immediate register
// - xor operand with immediate, write back
// - mask zero flag on result 0000h
// - mask ones flag on result ffffh
// - xor opcode bits 15:3 0010111011010
module mcwsx_core
  import mcwsx_pkg::*;
(
  // clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  rstn,
  // instruction fetch
  input  wire logic [WORD_W-1:0]     instr,
  input  wire logic                  instr_valid,
  output logic                       instr_ready,
  output logic [PC_W-1:0]            microprogram_counter,
  // wait table
  input  wire logic [ROWS-1:0]       wait_cond,
  input  wire logic [ROWS*PC_W-1:0]  wait_dest,
  output logic [ROWS-1:0]            wait_rows_reg,
  output logic                       waiting,
  // spi backdoor source registers
  input  wire logic [WORD_W-1:0]     spi_addr_value,
  input  wire logic [WORD_W-1:0]     spi_data_value,
  input  wire logic                  addr_from_imm,
  // spi backdoor request
  output logic                       spi_wr_req,
  output logic [WORD_W-1:0]          spi_wr_addr,
  output logic [WORD_W-1:0]          spi_wr_data,
  output logic                       spi_wr_done,
  // alu
  input  wire logic [WORD_W-1:0]     alu_immediate_reg,
  input  wire logic [ALU_REGS*WORD_W-1:0] alu_regs_in,
  output logic                       alu_we,
  output logic [2:0]                 alu_wsel,
  output logic [WORD_W-1:0]          alu_wdata,
  output logic                       mask_zero_flag,
  output logic                       mask_ones_flag
);
  mcwsx_state_t      state_reg;
  logic [PC_W-1:0]   pc_reg;
  logic [ROWS-1:0]   sel_rows;
  logic [ROWS-1:0]   fired;
  logic              is_wait5;
  logic              is_wait6;
  logic              is_spiwr;
  logic              is_xor;
  logic              issue;
  logic [1:0]        spi_cnt_reg;
  logic [WORD_W-1:0] source_operand;
  logic [WORD_W-1:0] xor_result;
  logic [PC_W-1:0]   dest_next;
  logic              fire_any;

  // opcode decode
  assign is_wait5 = instr[15:WAIT_OP_LSB] == WAIT5_OP;
  assign is_wait6 = instr[15:WAIT_OP_LSB] == WAIT6_OP;
  assign is_spiwr = instr == SPIWR_OP;
  assign is_xor   = instr[15:XOR_OP_LSB] == XOR_OP;
  assign issue    = instr_valid && instr_ready;

  mcwsx_wait_sel u_sel (
    .field        (instr[4:0]),
    .row6_variant (is_wait6),
    .row_enable   (sel_rows)
  );

  // handshake: new instruction accepted only while running
  assign instr_ready          = state_reg == MCWSX_RUN;
  assign waiting              = state_reg == MCWSX_WAIT;
  assign microprogram_counter = pc_reg;

  // lowest enabled row that fires wins
  assign fired = wait_rows_reg & wait_cond;
  assign fire_any = |fired;
  always_comb begin
    dest_next = pc_reg;
    for (int i = ROWS - 1; i >= 0; i--) begin
      if (fired[i]) begin
        dest_next = wait_dest[i*PC_W +: PC_W];
      end
    end
  end

  // sequencer
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= MCWSX_RUN;
    end else begin
      unique case (state_reg)
        MCWSX_RUN: begin
          if (issue && (is_wait5 || is_wait6)) begin
            state_reg <= MCWSX_WAIT;
          end else if (issue && is_spiwr) begin
            state_reg <= MCWSX_SPI;
          end
        end
        MCWSX_WAIT: begin
          if (fire_any) begin
            state_reg <= MCWSX_RUN;
          end
        end
        MCWSX_SPI: begin
          if (spi_cnt_reg == SPIWR_CYCLES - 2'h1) begin
            state_reg <= MCWSX_RUN;
          end
        end
        default: state_reg <= MCWSX_RUN;
      endcase
    end
  end

  // active row mask latched at wait issue; zero mask never fires
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wait_rows_reg <= '0;
    end else if (issue && (is_wait5 || is_wait6)) begin
      wait_rows_reg <= sel_rows;
    end else if (state_reg == MCWSX_WAIT && fire_any) begin
      wait_rows_reg <= '0;
    end
  end

  // program counter: hold during wait and spi, jump on fired row
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pc_reg <= PC_RST;
    end else if (state_reg == MCWSX_WAIT) begin
      pc_reg <= dest_next;
    end else if (state_reg == MCWSX_SPI) begin
      if (spi_cnt_reg == SPIWR_CYCLES - 2'h1) begin
        pc_reg <= pc_reg + 10'h001;
      end
    end else if (issue && !(is_wait5 || is_wait6) && !is_spiwr) begin
      pc_reg <= pc_reg + 10'h001;
    end
  end

  // backdoor write: operands sampled at issue; later changes do not affect the write
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      spi_wr_addr <= WORD_RST;
      spi_wr_data <= WORD_RST;
    end else if (issue && is_spiwr) begin
      spi_wr_addr <= addr_from_imm ? alu_immediate_reg : spi_addr_value;
      spi_wr_data <= spi_data_value;
    end
  end

  // request pulse and completion count
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      spi_wr_req  <= 1'b0;
      spi_wr_done <= 1'b0;
      spi_cnt_reg <= 2'h0;
    end else begin
      spi_wr_req  <= issue && is_spiwr;
      spi_wr_done <= state_reg == MCWSX_SPI && spi_cnt_reg == SPIWR_CYCLES - 2'h1;
      if (issue && is_spiwr) begin
        spi_cnt_reg <= 2'h1;
      end else if (state_reg == MCWSX_SPI) begin
        spi_cnt_reg <= spi_cnt_reg + 2'h1;
      end else begin
        spi_cnt_reg <= 2'h0;
      end
    end
  end

  // xor datapath
  assign source_operand = alu_regs_in[instr[2:0]*WORD_W +: WORD_W];
  assign xor_result     = source_operand ^ alu_immediate_reg;

  // xor write-back and flags, one cycle
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      alu_we         <= 1'b0;
      alu_wsel       <= 3'h0;
      alu_wdata      <= WORD_RST;
      mask_zero_flag <= 1'b0;
      mask_ones_flag <= 1'b0;
    end else begin
      alu_we <= issue && is_xor;
      if (issue && is_xor) begin
        alu_wsel       <= instr[2:0];
        alu_wdata      <= xor_result;
        mask_zero_flag <= xor_result == WORD_RST;
        mask_ones_flag <= xor_result == ALL_ONES;
      end
    end
  end

  // assertions
  a_wait_holds_pc: assert property (@(posedge core_clk) disable iff (!rstn)
    state_reg == MCWSX_WAIT && !fire_any |=> $stable(pc_reg))
    else $error("pc moved during wait");
  a_wait_jump_dest: assert property (@(posedge core_clk) disable iff (!rstn)
    state_reg == MCWSX_WAIT && fire_any |=> pc_reg == $past(dest_next)
      && state_reg == MCWSX_RUN)
    else $error("wait did not jump to destination");
  a_zero_mask_stays: assert property (@(posedge core_clk) disable iff (!rstn)
    issue && is_wait5 && instr[4:0] == 5'h00 |=> waiting [*8])
    else $error("zero row mask left wait");
  a_wait6_has_row6: assert property (@(posedge core_clk) disable iff (!rstn)
    issue && is_wait6 && instr[4:0] != 5'h1e && instr[4:0] != 5'h1f
      |=> wait_rows_reg[5])
    else $error("row6 wait lacks row 6");
  a_wait5_no_row6: assert property (@(posedge core_clk) disable iff (!rstn)
    issue && is_wait5 |=> !wait_rows_reg[5] && waiting)
    else $error("row6 enabled in row1-5 wait");
  // ready returns, with the done pulse, at the second edge after issue
  a_spi_two_cycles: assert property (@(posedge core_clk) disable iff (!rstn)
    issue && is_spiwr |=> spi_wr_req && !instr_ready
      ##1 instr_ready && spi_wr_done && !spi_wr_req)
    else $error("backdoor write timing wrong");
  a_spi_operands: assert property (@(posedge core_clk) disable iff (!rstn)
    issue && is_spiwr |=> spi_wr_data == $past(spi_data_value)
      && spi_wr_addr == ($past(addr_from_imm) ? $past(alu_immediate_reg)
      : $past(spi_addr_value)))
    else $error("backdoor operands not sampled at issue");
  a_xor_result: assert property (@(posedge core_clk) disable iff (!rstn)
    issue && is_xor |=> alu_we && alu_wdata == ($past(source_operand)
      ^ $past(alu_immediate_reg)))
    else $error("xor result wrong");
  a_xor_zero_flag: assert property (@(posedge core_clk) disable iff (!rstn)
    alu_we |-> mask_zero_flag == (alu_wdata == 16'h0000))
    else $error("mask zero flag wrong");
  a_xor_ones_flag: assert property (@(posedge core_clk) disable iff (!rstn)
    alu_we |-> mask_ones_flag == (alu_wdata == 16'hffff))
    else $error("mask ones flag wrong");
  a_xor_one_cycle: assert property (@(posedge core_clk) disable iff (!rstn)
    issue && is_xor |=> instr_ready && pc_reg == $past(pc_reg) + 10'h001)
    else $error("xor not single cycle");

  c_wait_fire: cover property (@(posedge core_clk) disable iff (!rstn)
    waiting && fire_any);
  c_spi_write: cover property (@(posedge core_clk) disable iff (!rstn) spi_wr_done);
  c_xor_zero: cover property (@(posedge core_clk) disable iff (!rstn)
    alu_we && mask_zero_flag);
  c_xor_ones: cover property (@(posedge core_clk) disable iff (!rstn)
    alu_we && mask_ones_flag);
endmodule

// ==== test/mcwsx_tb.sv ====
// self-checking bench for the wait, backdoor spi write and xor decoder
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin error_cnt++; $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb
  import mcwsx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic                       core_clk;
  logic                       rstn;
  logic [WORD_W-1:0]          instr;
  logic                       instr_valid;
  logic                       instr_ready;
  logic [PC_W-1:0]            microprogram_counter;
  logic [ROWS-1:0]            wait_cond;
  logic [ROWS*PC_W-1:0]       wait_dest;
  logic [ROWS-1:0]            wait_rows_reg;
  logic                       waiting;
  logic [WORD_W-1:0]          spi_addr_value;
  logic [WORD_W-1:0]          spi_data_value;
  logic                       addr_from_imm;
  logic                       spi_wr_req;
  logic [WORD_W-1:0]          spi_wr_addr;
  logic [WORD_W-1:0]          spi_wr_data;
  logic                       spi_wr_done;
  logic [WORD_W-1:0]          alu_immediate_reg;
  logic [ALU_REGS*WORD_W-1:0] alu_regs_in;
  logic                       alu_we;
  logic [2:0]                 alu_wsel;
  logic [WORD_W-1:0]          alu_wdata;
  logic                       mask_zero_flag;
  logic                       mask_ones_flag;
  logic [PC_W-1:0]            pc_seen;
  int                         error_cnt;
  int                         total_checks;
  int                         cyc;

  mcwsx_core dut (.core_clk(core_clk), .rstn(rstn), .instr(instr), .instr_valid(instr_valid),
    .instr_ready(instr_ready), .microprogram_counter(microprogram_counter),
    .wait_cond(wait_cond), .wait_dest(wait_dest), .wait_rows_reg(wait_rows_reg),
    .waiting(waiting), .spi_addr_value(spi_addr_value), .spi_data_value(spi_data_value),
    .addr_from_imm(addr_from_imm), .spi_wr_req(spi_wr_req), .spi_wr_addr(spi_wr_addr),
    .spi_wr_data(spi_wr_data), .spi_wr_done(spi_wr_done),
    .alu_immediate_reg(alu_immediate_reg), .alu_regs_in(alu_regs_in), .alu_we(alu_we),
    .alu_wsel(alu_wsel), .alu_wdata(alu_wdata), .mask_zero_flag(mask_zero_flag),
    .mask_ones_flag(mask_ones_flag));

  // 200 mhz clock
  always #2.5 core_clk = ~core_clk;

  // hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      stop_test();
    end
  end

  task automatic stop_test();
    if (error_cnt == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // offer one word; returns at the edge that takes it
  task automatic issue(input logic [15:0] w);
    @(posedge core_clk);
    instr       <= w;
    instr_valid <= 1'b1;
    #1 pc_seen = microprogram_counter;
    @(posedge core_clk);
    instr_valid <= 1'b0;
  endtask

  // xor of one alu register with the immediate
  task automatic xor_case(input int sel, input logic [15:0] v, input logic [15:0] imm);
    logic [15:0] r;
    r = v ^ imm;
    @(posedge core_clk);
    alu_regs_in[sel*16 +: 16] <= v;
    alu_immediate_reg         <= imm;
    issue({XOR_OP, sel[2:0]});
    #1 `CHK(alu_we, 1'b1)
    `CHK(alu_wsel, sel[2:0])
    `CHK(alu_wdata, r)
    `CHK(mask_zero_flag, r == 16'h0000)
    `CHK(mask_ones_flag, r == 16'hffff)
    `CHK(microprogram_counter, pc_seen + 10'h001)
    @(posedge core_clk);
    #1 `CHK(alu_we, 1'b0)
  endtask

  // backdoor write; spi address and data registers disturbed right after issue
  task automatic spi_case(input logic imm_sel, input logic [15:0] exp_addr);
    @(posedge core_clk);
    spi_addr_value    <= 16'h0171;
    spi_data_value    <= 16'h0125;
    alu_immediate_reg <= 16'h02a4;
    addr_from_imm     <= imm_sel;
    issue(SPIWR_OP);
    spi_addr_value <= 16'hdead;
    spi_data_value <= 16'hbeef;
    #1 `CHK(spi_wr_req, 1'b1)
    `CHK(instr_ready, 1'b0)
    `CHK(spi_wr_addr, exp_addr)
    `CHK(spi_wr_data, 16'h0125)
    @(posedge core_clk);
    #1 `CHK({spi_wr_req, spi_wr_done, instr_ready}, 3'h3)
    `CHK(spi_wr_addr, exp_addr)
    `CHK(spi_wr_data, 16'h0125)
    `CHK(microprogram_counter, pc_seen + 10'h001)
    @(posedge core_clk);
    #1 `CHK({spi_wr_done, instr_ready}, 2'h1)
  endtask

  // wait; non-enabled rows fire first and a word is offered meanwhile
  task automatic wait_case(input logic six, input logic [4:0] f, input logic [5:0] rows,
                           input logic [5:0] fire, input logic [9:0] dest);
    int n;
    issue({six ? WAIT6_OP : WAIT5_OP, f});
    @(posedge core_clk);
    #1 `CHK(waiting, 1'b1)
    `CHK(wait_rows_reg, rows)
    @(posedge core_clk);
    instr       <= {XOR_OP, 3'h1};
    instr_valid <= 1'b1;
    wait_cond   <= ~rows;
    repeat (8) @(posedge core_clk);
    #1 `CHK({waiting, instr_ready, alu_we}, 3'h4)
    `CHK(microprogram_counter, pc_seen)
    if (fire != 6'h00) begin
      @(posedge core_clk);
      instr_valid <= 1'b0;
      wait_cond   <= fire | ~rows;
      n = 0;
      while (waiting === 1'b1 && n < 6) begin
        @(posedge core_clk);
        #1 n++;
      end
      `CHK(waiting, 1'b0)
      `CHK(microprogram_counter, dest)
      @(posedge core_clk);
      wait_cond <= 6'h00;
    end
  endtask

  // reset and the reset state of the outputs
  task automatic do_reset();
    @(posedge core_clk);
    rstn        <= 1'b0;
    instr_valid <= 1'b0;
    wait_cond   <= 6'h00;
    repeat (10) @(posedge core_clk);
    rstn <= 1'b1;
    #1 `CHK({microprogram_counter, waiting, instr_ready}, 12'h001)
    `CHK({spi_wr_req, spi_wr_done, alu_we, mask_zero_flag, mask_ones_flag}, 5'h00)
  endtask

  // main sequence
  initial begin
    core_clk = 1'b0;
    rstn = 1'b0;
    instr = 16'h0000;
    instr_valid = 1'b0;
    wait_cond = 6'h00;
    spi_addr_value = 16'h0000;
    spi_data_value = 16'h0000;
    addr_from_imm = 1'b0;
    alu_immediate_reg = 16'h0000;
    error_cnt = 0;
    total_checks = 0;
    cyc = 0;
    for (int i = 0; i < ROWS; i++) wait_dest[i*10 +: 10] = 10'h3c0 + 10'(i);
    for (int k = 0; k < ALU_REGS; k++) alu_regs_in[k*16 +: 16] = {4{4'(k)}};
    do_reset();
    xor_case(5, 16'h1234, 16'h1234);
    xor_case(2, 16'h0f0f, 16'hf0f0);
    xor_case(7, 16'ha5a5, 16'h0001);
    spi_case(1'b0, 16'h0171);
    spi_case(1'b1, 16'h02a4);
    wait_case(1'b0, 5'h04, 6'h04, 6'h04, 10'h3c2);
    wait_case(1'b0, 5'h1f, 6'h1f, 6'h18, 10'h3c3);
    wait_case(1'b1, 5'h00, 6'h20, 6'h20, 10'h3c5);
    wait_case(1'b1, 5'h06, 6'h23, 6'h02, 10'h3c1);
    wait_case(1'b0, 5'h00, 6'h00, 6'h00, 10'h000);
    do_reset();
    xor_case(0, 16'hffff, 16'h0000);
    stop_test();
  end
endmodule
